/* File: scsf_top.sv */
// serial channel status flags: receive, transmit, break, overrun, buffer end
//
// Overview of operation
// RULE1: rx ready sets on a complete unread character; rx holding read clears it.
// RULE2: rx ready reads zero while receiver off; pending character shows on re-enable.
// RULE3: tx ready low while holding full, break pending or transmitter off.
// RULE4: tx ready goes high on transmitter enable whenever holding register empty and no break pending.
// RULE5: break flag sets on break or break end; cleared by clear-status command.
// RULE6: rx end flag sets when rx counter hits zero; counter writes clear it. Code sets it on a zero count write while the next counter is zero.
// RULE7: tx end flag sets when tx counter hits zero; counter writes clear it. Code sets it on a zero count write while the next counter is zero.
// RULE8: overrun flag sets on overrun; cleared by clear-status command.
// RULE9: new character while rx ready set is overrun; new character replaces held. Code tests the held flag, so overrun also sets with receiver off.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/10ps
`include "scsf_consts.svh"
module scsf_top
  import scsf_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic [`SCSF_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic [31:0]                 rdata,
  input  wire scsf_pkg::scsf_char_t    rx_char,
  input  wire logic                   line_break,
  input  wire logic                   tx_shift_take,
  output logic [7:0]                  tx_shift_data,
  output logic                        tx_break_active,
  input  wire logic                   rx_dma_step,
  input  wire logic                   tx_dma_step
);
  import scsf_pkg::*;

  if (CNT_W < 1 || CNT_W > 32)
  begin : g_bad_width
    $error("scsf_top: bad counter width");
  end

  function automatic logic hit(input logic [`SCSF_ADDR_W-1:0] a,
                               input logic [`SCSF_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic wr_ctrl;
  logic wr_thr;
  logic rd_rhr;
  logic cmd_clr;
  assign wr_ctrl = wr && hit(addr, `SCSF_OFF_CONTROL);
  assign wr_thr  = wr && hit(addr, `SCSF_OFF_TX_HOLD);
  assign rd_rhr  = rd && hit(addr, `SCSF_OFF_RX_HOLD);
  assign cmd_clr = wr_ctrl && wdata[`SCSF_CR_CLEAR_STATUS];

  // the line break level is asynchronous to clk
  logic brk_s1;
  logic brk_s2;
  logic brk_prev;

  logic       rx_en;
  logic       tx_en;
  logic       rx_held;
  logic [7:0] rx_data;
  logic       tx_full;
  logic [7:0] tx_data;
  logic       brk_pend;
  logic       break_seen;
  logic       overrun_flag;
  logic       next_rx_en;
  logic       next_tx_en;
  logic       next_rx_held;
  logic [7:0] next_rx_data;
  logic       next_tx_full;
  logic [7:0] next_tx_data;
  logic       next_brk_pend;
  logic       next_break_seen;
  logic       next_overrun;
  logic       next_tx_break_active;
  logic [7:0] next_tx_shift_data;
  logic       rx_char_ready;
  logic       tx_holding_ready;
  logic       brk_edge;

  assign brk_edge         = brk_s2 ^ brk_prev;
  // held character survives a disable so it reappears on re-enable
  assign rx_char_ready    = rx_en && rx_held; // see RULE1 see RULE2
  assign tx_holding_ready = tx_en && !tx_full && !brk_pend; // see RULE3 see RULE4

  always_comb
  begin
    next_rx_en           = rx_en;
    next_tx_en           = tx_en;
    next_rx_held         = rx_held;
    next_rx_data         = rx_data;
    next_tx_full         = tx_full;
    next_tx_data         = tx_data;
    next_brk_pend        = brk_pend;
    next_break_seen      = break_seen;
    next_overrun         = overrun_flag;
    next_tx_break_active = tx_break_active;
    next_tx_shift_data   = tx_shift_data;
    if (wr_ctrl)
    begin
      if (wdata[`SCSF_CR_RX_EN])
        next_rx_en = 1'b1;
      if (wdata[`SCSF_CR_RX_DIS])
        next_rx_en = 1'b0;
      if (wdata[`SCSF_CR_TX_EN])
        next_tx_en = 1'b1;
      if (wdata[`SCSF_CR_TX_DIS])
        next_tx_en = 1'b0;
      if (wdata[`SCSF_CR_START_BREAK])
        next_brk_pend = 1'b1;
      if (wdata[`SCSF_CR_STOP_BREAK])
        next_tx_break_active = 1'b0;
    end
    if (rd_rhr)
      next_rx_held = 1'b0; // see RULE1
    if (cmd_clr)
    begin
      next_break_seen = 1'b0;
      next_overrun    = 1'b0;
    end
    // sets placed after clears so a same-cycle event wins
    if (rx_char.valid)
    begin
      if (rx_held && !rd_rhr)
        next_overrun = 1'b1; // see RULE8 see RULE9
      next_rx_held = 1'b1; // see RULE1
      next_rx_data = rx_char.data; // see RULE9
    end
    if (brk_edge)
      next_break_seen = 1'b1; // see RULE5
    if (wr_thr)
    begin
      next_tx_full = 1'b1; // see RULE3
      next_tx_data = wdata[7:0];
    end
    // shifter takes the break first, then characters; only when enabled
    if (tx_en && tx_shift_take)
    begin
      if (brk_pend)
      begin
        next_brk_pend        = 1'b0;
        next_tx_break_active = 1'b1;
      end
      else if (tx_full && !wr_thr)
      begin
        next_tx_full       = 1'b0; // see RULE4
        next_tx_shift_data = tx_data;
      end
      else if (tx_full)
        next_tx_shift_data = tx_data;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      brk_s1          <= 1'b0;
      brk_s2          <= 1'b0;
      brk_prev        <= 1'b0;
      rx_en           <= 1'b0;
      tx_en           <= 1'b0;
      rx_held         <= 1'b0;
      rx_data         <= 8'h00;
      tx_full         <= 1'b0;
      tx_data         <= 8'h00;
      brk_pend        <= 1'b0;
      break_seen      <= 1'b0;
      overrun_flag    <= 1'b0;
      tx_break_active <= 1'b0;
      tx_shift_data   <= 8'h00;
    end
    else
    begin
      brk_s1          <= line_break;
      brk_s2          <= brk_s1;
      brk_prev        <= brk_s2;
      rx_en           <= next_rx_en;
      tx_en           <= next_tx_en;
      rx_held         <= next_rx_held;
      rx_data         <= next_rx_data;
      tx_full         <= next_tx_full;
      tx_data         <= next_tx_data;
      brk_pend        <= next_brk_pend;
      break_seen      <= next_break_seen;
      overrun_flag    <= next_overrun;
      tx_break_active <= next_tx_break_active;
      tx_shift_data   <= next_tx_shift_data;
    end
  end

  logic [CNT_W-1:0] rx_cnt;
  logic [CNT_W-1:0] rx_ncnt;
  logic [CNT_W-1:0] tx_cnt;
  logic [CNT_W-1:0] tx_ncnt;
  logic             rx_buffer_end;
  logic             tx_buffer_end;

  scsf_counter #(.CNT_W(CNT_W)) u_rx_cnt (
    .clk            (clk),
    .resetn         (resetn),
    .wr_count       (wr && hit(addr, `SCSF_OFF_RX_COUNT)),
    .wr_next        (wr && hit(addr, `SCSF_OFF_RX_NCOUNT)),
    .wdata          (wdata[CNT_W-1:0]),
    .step           (rx_dma_step),
    .count          (rx_cnt),
    .next_count_val (rx_ncnt),
    .buffer_end     (rx_buffer_end) // see RULE6
  );

  scsf_counter #(.CNT_W(CNT_W)) u_tx_cnt (
    .clk            (clk),
    .resetn         (resetn),
    .wr_count       (wr && hit(addr, `SCSF_OFF_TX_COUNT)),
    .wr_next        (wr && hit(addr, `SCSF_OFF_TX_NCOUNT)),
    .wdata          (wdata[CNT_W-1:0]),
    .step           (tx_dma_step),
    .count          (tx_cnt),
    .next_count_val (tx_ncnt),
    .buffer_end     (tx_buffer_end) // see RULE7
  );

  logic [31:0] status_word;
  logic [31:0] next_rdata;
  always_comb
  begin
    status_word = 32'h0;
    status_word[`SCSF_SR_RX_READY] = rx_char_ready;
    status_word[`SCSF_SR_TX_READY] = tx_holding_ready;
    status_word[`SCSF_SR_BREAK]    = break_seen;
    status_word[`SCSF_SR_RX_END]   = rx_buffer_end;
    status_word[`SCSF_SR_TX_END]   = tx_buffer_end;
    status_word[`SCSF_SR_OVERRUN]  = overrun_flag;
    status_word[`SCSF_SR_RX_EN]    = rx_en;
    status_word[`SCSF_SR_TX_EN]    = tx_en;
    next_rdata = 32'h0;
    if (rd)
    begin
      case (addr)
        `SCSF_OFF_STATUS:    next_rdata = status_word;
        `SCSF_OFF_RX_HOLD:   next_rdata = {24'h0, rx_data};
        `SCSF_OFF_TX_HOLD:   next_rdata = {24'h0, tx_data};
        `SCSF_OFF_RX_COUNT:  next_rdata = 32'(rx_cnt);
        `SCSF_OFF_RX_NCOUNT: next_rdata = 32'(rx_ncnt);
        `SCSF_OFF_TX_COUNT:  next_rdata = 32'(tx_cnt);
        `SCSF_OFF_TX_NCOUNT: next_rdata = 32'(tx_ncnt);
        default:             next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= 32'h0;
    else
      rdata <= next_rdata;
  end

  property p_rx_clear;
    @(posedge clk) disable iff (!resetn) rd_rhr && !rx_char.valid |=> !rx_char_ready;
  endproperty
  a_rx_clear: assert property (p_rx_clear) // see RULE1
    else $error("rx ready not cleared by holding read");
  // checks the read path, not just the gating expression
  property p_rx_off;
    @(posedge clk) disable iff (!resetn)
      !rx_en && rd && hit(addr, `SCSF_OFF_STATUS) |=> !rdata[`SCSF_SR_RX_READY];
  endproperty
  a_rx_off: assert property (p_rx_off) // see RULE2
    else $error("rx ready read as set while receiver off");
  property p_rx_reenable;
    @(posedge clk) disable iff (!resetn)
      wr_ctrl && wdata[`SCSF_CR_RX_EN] && !wdata[`SCSF_CR_RX_DIS] && rx_held && !rd_rhr
      |=> rx_char_ready;
  endproperty
  a_rx_reenable: assert property (p_rx_reenable) // see RULE2
    else $error("held character not shown after receiver enable");
  property p_tx_write;
    @(posedge clk) disable iff (!resetn) wr_thr |=> !tx_holding_ready;
  endproperty
  a_tx_write: assert property (p_tx_write) // see RULE3
    else $error("tx ready not cleared by holding write");
  property p_tx_enable;
    @(posedge clk) disable iff (!resetn)
      wr_ctrl && wdata[`SCSF_CR_TX_EN] && !wdata[`SCSF_CR_TX_DIS]
      && !wdata[`SCSF_CR_START_BREAK] && !tx_full && !brk_pend |=> tx_holding_ready;
  endproperty
  a_tx_enable: assert property (p_tx_enable) // see RULE4
    else $error("tx ready low after enable with empty holding register");
  property p_break_set;
    @(posedge clk) disable iff (!resetn) brk_edge |=> break_seen;
  endproperty
  a_break_set: assert property (p_break_set) // see RULE5
    else $error("break edge not flagged");
  property p_break_hold;
    @(posedge clk) disable iff (!resetn) break_seen && !cmd_clr |=> break_seen;
  endproperty
  a_break_hold: assert property (p_break_hold) // see RULE5
    else $error("break flag dropped without clear");
  property p_overrun;
    @(posedge clk) disable iff (!resetn)
      rx_char.valid && rx_held && !rd_rhr |=> overrun_flag && rx_data == $past(rx_char.data);
  endproperty
  a_overrun: assert property (p_overrun) // see RULE8 see RULE9
    else $error("overrun not flagged or data not replaced");
  property p_ovr_hold;
    @(posedge clk) disable iff (!resetn) overrun_flag && !cmd_clr |=> overrun_flag;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) // see RULE8
    else $error("overrun dropped without clear");
  property p_rx_end;
    @(posedge clk) disable iff (!resetn)
      rx_dma_step && rx_cnt == CNT_W'(1) && rx_ncnt == '0 && !wr |=> rx_buffer_end;
  endproperty
  a_rx_end: assert property (p_rx_end) // see RULE6
    else $error("rx end flag not set");
  property p_tx_end;
    @(posedge clk) disable iff (!resetn)
      wr && hit(addr, `SCSF_OFF_TX_COUNT) && wdata[CNT_W-1:0] != '0 |=> !tx_buffer_end;
  endproperty
  a_tx_end: assert property (p_tx_end) // see RULE7
    else $error("tx end flag not cleared by counter write");
endmodule

/* File: scsf_consts.svh */
// constants for the serial channel status flag block
`ifndef SCSF_CONSTS_SVH
`define SCSF_CONSTS_SVH
`define SCSF_ADDR_W          4
`define SCSF_OFF_CONTROL     4'h0
`define SCSF_OFF_STATUS      4'h1
`define SCSF_OFF_RX_HOLD     4'h2
`define SCSF_OFF_TX_HOLD     4'h3
`define SCSF_OFF_RX_COUNT    4'h4
`define SCSF_OFF_RX_NCOUNT   4'h5
`define SCSF_OFF_TX_COUNT    4'h6
`define SCSF_OFF_TX_NCOUNT   4'h7
`define SCSF_CR_RX_EN        4
`define SCSF_CR_RX_DIS       5
`define SCSF_CR_TX_EN        6
`define SCSF_CR_TX_DIS       7
`define SCSF_CR_CLEAR_STATUS 8
`define SCSF_CR_START_BREAK  9
`define SCSF_CR_STOP_BREAK   10
`define SCSF_SR_RX_READY     0
`define SCSF_SR_TX_READY     1
`define SCSF_SR_BREAK        2
`define SCSF_SR_RX_END       3
`define SCSF_SR_TX_END       4
`define SCSF_SR_OVERRUN      5
`define SCSF_SR_RX_EN        16
`define SCSF_SR_TX_EN        17
`endif

/* File: scsf_pkg.sv */
// types shared by the serial channel status flag block
package scsf_pkg;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } scsf_char_t;
  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [3:0]           addr;
    logic [31:0]          wdata;
  } scsf_bus_t;
endpackage

/* File: scsf_counter.sv */
// one transfer counter with a next counter and a sticky end-of-buffer flag
`timescale 1ns/10ps
module scsf_counter
  import scsf_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             wr_count,
  input  wire logic             wr_next,
  input  wire logic [CNT_W-1:0] wdata,
  input  wire logic             step,
  output logic [CNT_W-1:0]      count,
  output logic [CNT_W-1:0]      next_count_val,
  output logic                  buffer_end
);
  // counter width must fit the 32-bit write data
  if (CNT_W < 1 || CNT_W > 32)
  begin : g_bad_width
    $error("scsf_counter: bad width");
  end
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] next_ncount;
  logic             next_end;
  always_comb
  begin
    next_count  = count;
    next_ncount = next_count_val;
    next_end    = buffer_end;
    if (step && count != '0)
    begin
      next_count = count - CNT_W'(1);
      if (count == CNT_W'(1))
      begin
        if (next_count_val != '0)
        begin
          // reload from the next counter so the flag only marks true end
          next_count  = next_count_val;
          next_ncount = '0;
        end
        else
          next_end = 1'b1;
      end
    end
    if (wr_count)
    begin
      next_count = wdata;
      next_end   = (wdata == '0) && (next_count_val == '0);
    end
    if (wr_next)
    begin
      next_ncount = wdata;
      next_end    = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count          <= '0;
      next_count_val <= '0;
      buffer_end     <= 1'b0;
    end
    else
    begin
      count          <= next_count;
      next_count_val <= next_ncount;
      buffer_end     <= next_end;
    end
  end
  property p_end_clear;
    @(posedge clk) disable iff (!resetn) wr_next |=> !buffer_end;
  endproperty
  a_end_clear: assert property (p_end_clear) // see RULE6 see RULE7
    else $error("end flag not cleared by next-counter write");
endmodule

/* File: scsf_peer.sv */
// far side model: serial peer, transmit shifter and dma stepping
`timescale 1ns/10ps
module scsf_peer
  import scsf_pkg::*;
(
  input  wire logic     clk,
  output scsf_char_t    rx_char,
  output logic          line_break,
  output logic          tx_shift_take,
  output logic          rx_dma_step,
  output logic          tx_dma_step
);
  initial
  begin
    rx_char = '0;
    line_break = 1'b0;
    tx_shift_take = 1'b0;
    rx_dma_step = 1'b0;
    tx_dma_step = 1'b0;
  end
  // data is inverted once valid drops so a stale byte can never pass for a new one
  task automatic send(input logic [7:0] d);
    @(posedge clk);
    rx_char <= '{1'b1, d};
    @(posedge clk);
    rx_char <= '{1'b0, ~d};
  endtask
  // shifter accepts one item after n idle cycles: 0 is prompt, larger is slow
  task automatic take_after(input int n);
    repeat (n) @(posedge clk);
    @(posedge clk);
    tx_shift_take <= 1'b1;
    @(posedge clk);
    tx_shift_take <= 1'b0;
  endtask
  task automatic dma(input int tx);
    @(posedge clk);
    rx_dma_step <= (tx == 0);
    tx_dma_step <= (tx != 0);
    @(posedge clk);
    rx_dma_step <= 1'b0;
    tx_dma_step <= 1'b0;
  endtask
  task automatic brk(input logic lvl);
    @(posedge clk);
    line_break <= lvl;
  endtask
endmodule

/* File: scsf_top_tb.sv */
// self-checking testbench for the serial channel status flag block
`timescale 1ns/10ps
`include "scsf_consts.svh"
module scsf_top_tb;
  import scsf_pkg::*;
  logic                    clk;
  logic                    resetn;
  logic                    wr;
  logic                    rd;
  logic [`SCSF_ADDR_W-1:0] addr;
  logic [`SCSF_ADDR_W-1:0] ca;
  logic [31:0]             wdata;
  logic [31:0]             rdata;
  logic [31:0]             got;
  logic [31:0]             seed;
  logic [7:0]              tx_shift_data;
  logic [7:0]              d1;
  logic [7:0]              d2;
  logic                    tx_break_active;
  logic                    line_break;
  logic                    tx_shift_take;
  logic                    rx_dma_step;
  logic                    tx_dma_step;
  scsf_char_t              rx_char;
  int                      errors;
  int                      compares;
  int                      n;

  scsf_top u_scsf_top (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rx_char(rx_char), .line_break(line_break),
    .tx_shift_take(tx_shift_take), .tx_shift_data(tx_shift_data),
    .tx_break_active(tx_break_active), .rx_dma_step(rx_dma_step), .tx_dma_step(tx_dma_step));
  scsf_peer u_scsf_peer (.clk(clk), .rx_char(rx_char), .line_break(line_break),
    .tx_shift_take(tx_shift_take), .rx_dma_step(rx_dma_step), .tx_dma_step(tx_dma_step));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  // read data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  function automatic logic [31:0] st(input logic [5:0] f, input logic [1:0] en);
    return {14'h0, en, 10'h0, f};
  endfunction
  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // f is {overrun, tx end, rx end, break, tx ready, rx ready}
  task automatic sts(input logic [5:0] f, input logic [1:0] en);
    rd_reg(`SCSF_OFF_STATUS);
    check(got, st(f, en));
  endtask
  task automatic ctl(input int b);
    wr_reg(`SCSF_OFF_CONTROL, 32'h1 << b);
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end

  initial
  begin
    seed = 32'hd01e8648;
    errors = 0;
    compares = 0;
    resetn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd_reg(`SCSF_OFF_STATUS);
    check(got, 32'h0);
    rd_reg(4'hf);
    check(got, 32'h0);
    wr_reg(`SCSF_OFF_RX_COUNT, 32'h5);
    wr_reg(`SCSF_OFF_TX_COUNT, 32'h5);
    endt("reset");
    ctl(`SCSF_CR_TX_EN);
    sts(6'h02, 2'b10);
    d1 = rnd8();
    wr_reg(`SCSF_OFF_TX_HOLD, {24'h0, d1});
    sts(6'h00, 2'b10);
    u_scsf_peer.take_after(3);
    repeat (2) @(posedge clk);
    #1 check({24'h0, tx_shift_data}, {24'h0, d1});
    sts(6'h02, 2'b10);
    ctl(`SCSF_CR_START_BREAK);
    sts(6'h00, 2'b10);
    u_scsf_peer.take_after(0);
    repeat (2) @(posedge clk);
    #1 check({31'h0, tx_break_active}, 32'h1);
    ctl(`SCSF_CR_STOP_BREAK);
    #1 check({31'h0, tx_break_active}, 32'h0);
    sts(6'h02, 2'b10);
    ctl(`SCSF_CR_TX_DIS);
    sts(6'h00, 2'b00);
    ctl(`SCSF_CR_TX_EN);
    sts(6'h02, 2'b10);
    endt("transmit");
    ctl(`SCSF_CR_RX_EN);
    repeat (3)
    begin
      d1 = rnd8();
      d2 = rnd8();
      u_scsf_peer.send(d1);
      sts(6'h03, 2'b11);
      u_scsf_peer.send(d2);
      sts(6'h23, 2'b11);
      rd_reg(`SCSF_OFF_RX_HOLD);
      check(got, {24'h0, d2});
      sts(6'h22, 2'b11);
      ctl(`SCSF_CR_CLEAR_STATUS);
      sts(6'h02, 2'b11);
    end
    u_scsf_peer.send(d1);
    ctl(`SCSF_CR_RX_DIS);
    sts(6'h02, 2'b10);
    ctl(`SCSF_CR_RX_EN);
    sts(6'h03, 2'b11);
    rd_reg(`SCSF_OFF_RX_HOLD);
    check(got, {24'h0, d1});
    endt("receive");
    for (int lvl = 1; lvl >= 0; lvl--)
    begin
      u_scsf_peer.brk(lvl[0]);
      repeat (5) @(posedge clk);
      sts(6'h06, 2'b11);
      ctl(`SCSF_CR_CLEAR_STATUS);
      sts(6'h02, 2'b11);
    end
    endt("break");
    for (int i = 0; i < 2; i++)
    begin
      ca = `SCSF_OFF_RX_COUNT + 4'(2 * i);
      n = int'(rnd8() % 8'h4) + 1;
      wr_reg(ca, 32'(n));
      repeat (n) u_scsf_peer.dma(i);
      sts(6'h02 | (6'h08 << i), 2'b11);
      wr_reg(ca + 4'h1, 32'h2);
      sts(6'h02, 2'b11);
      wr_reg(ca, 32'h1);
      u_scsf_peer.dma(i);
      sts(6'h02, 2'b11);
      repeat (2) u_scsf_peer.dma(i);
      sts(6'h02 | (6'h08 << i), 2'b11);
      wr_reg(ca, 32'h3);
      sts(6'h02, 2'b11);
    end
    endt("counters");
    give_verdict();
  end
endmodule
